// >>> pkg/tab_cfg.svh
// Register map, field positions, reset values and timing constants
`ifndef TAB_CFG_SVH
`define TAB_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define TAB_OFF_STATUS      6'h01
`define TAB_OFF_BUFCTL      6'h02
`define TAB_OFF_REFCTL      6'h03

// ************************************************************
// Status register field positions
// ************************************************************
`define TAB_ST_COMPLETE     11
`define TAB_CHANNELS        9

// ************************************************************
// Buffer control field positions, buffer depth and trigger level step
// ************************************************************
`define TAB_BC_ENABLE       15
`define TAB_BC_ONESHOT      14
`define TAB_BC_LEVEL_HI     13
`define TAB_BC_LEVEL_LO     11
`define TAB_BC_FULL         10
`define TAB_BC_EMPTY        9
`define TAB_BUF_DEPTH       7'h40
`define TAB_LEVEL_STEP      7'h08

// ************************************************************
// Reference control field positions and reset values
// ************************************************************
`define TAB_RC_SPARE        5
`define TAB_RC_SOURCE       4
`define TAB_RC_DELAY_HI     3
`define TAB_RC_DELAY_LO     2
`define TAB_RC_SLEEP        1
`define TAB_RC_LEVEL        0
`define TAB_RC_SLEEP_RST    1'h1

// ************************************************************
// Timing
// ************************************************************
`define TAB_CLK_MHZ         50
`define TAB_WAKE1_US        100
`define TAB_WAKE2_US        500
`define TAB_WAKE3_US        1000
`define TAB_WAKE1_CYC       (`TAB_WAKE1_US * `TAB_CLK_MHZ)
`define TAB_WAKE2_CYC       (`TAB_WAKE2_US * `TAB_CLK_MHZ)
`define TAB_WAKE3_CYC       (`TAB_WAKE3_US * `TAB_CLK_MHZ)

`endif

// >>> pkg/tab_pkg.sv
// Types shared by the touch converter status and reference block
package tab_pkg;

  // ************************************************************
  // Register fields
  // ************************************************************
  typedef struct packed {
    logic       spare;
    logic       source;
    logic [1:0] delay;
    logic       sleep;
    logic       level;
  } tab_ref_type;

  typedef struct packed {
    logic       enable;
    logic       oneshot;
    logic [2:0] level;
  } tab_buf_type;

  // ************************************************************
  // Reference sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    TAB_REF_IDLE,
    TAB_REF_WAKE,
    TAB_REF_READY
  } tab_ref_state_type;

endpackage

// >>> logic/tab_top.sv
// Status flags, result buffer control and reference sequencing
// What this block does
// - X flag D10 set on result, cleared after read
// - Y flag D9 set on result, cleared after read
// - Pressure flags D8, D7 set, cleared after read
// - Battery flag D6 set, cleared after read
// - Spare input flags D4, D3 likewise
// - Temperature flags D2, D1 likewise
// - Channel flags meaningless while buffer mode active
// - D15 low disables buffer, resets all pointers
// - D14 selects continuous or single shot mode
// - Trigger level is eight times code plus one
// - Full flag D10 set at 64 unread
// - Empty flag D9 set when none unread
// - D4 selects external or internal reference
// - D3-D2 wakeup wait none, 100, 500, 1000 us
// - Wait only for internal, sleeping reference
// - D1 sleeps reference between conversions, resets 1
// - External mode keeps internal reference powered down
// - D0 selects 1.25 V or 2.50 V
// - Set complete flag clears after all read
`include "tab_cfg.svh"

module tab_top #(
  parameter int P_WAKE1_CYC = `TAB_WAKE1_CYC,
  parameter int P_WAKE2_CYC = `TAB_WAKE2_CYC,
  parameter int P_WAKE3_CYC = `TAB_WAKE3_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_r,
  output logic             reg_rvalid_r,
  input  wire logic [8:0]  result_stored,
  input  wire logic [8:0]  result_read_done,
  input  wire logic        set_done,
  input  wire logic        buf_push,
  input  wire logic        buf_pop,
  input  wire logic        conv_request,
  output logic             set_complete_flag_r,
  output logic             buffer_full_flag_r,
  output logic             buffer_empty_flag_r,
  output logic             buffer_trigger_r,
  output logic             conv_hold_r,
  output logic             ref_power_on_r,
  output logic             meas_ready_r,
  output logic             reference_source_select_r,
  output logic             internal_level_select_r,
  output logic      [5:0]  buffer_read_pointer_r,
  output logic      [5:0]  buffer_write_pointer_r,
  output logic      [5:0]  buffer_trigger_pointer_r
);

  // ************************************************************
  // Register decode
  // ************************************************************
  tab_pkg::tab_ref_type ref_r;
  tab_pkg::tab_buf_type buf_r;
  wire logic hit_status = (reg_addr == `TAB_OFF_STATUS);
  wire logic hit_bufctl = (reg_addr == `TAB_OFF_BUFCTL);
  wire logic hit_refctl = (reg_addr == `TAB_OFF_REFCTL);
  wire logic wr_bufctl  = reg_wr & hit_bufctl;
  wire logic wr_refctl  = reg_wr & hit_refctl;

  // Only documented fields are captured, the rest are dropped
  wire tab_pkg::tab_buf_type buf_nxt = wr_bufctl ? tab_pkg::tab_buf_type'{
    enable:  reg_wdata[`TAB_BC_ENABLE],
    oneshot: reg_wdata[`TAB_BC_ONESHOT],
    level:   reg_wdata[`TAB_BC_LEVEL_HI:`TAB_BC_LEVEL_LO]
  } : buf_r;
  // Spare bit kept as stored; host is expected to write zero
  wire tab_pkg::tab_ref_type ref_nxt = wr_refctl ? tab_pkg::tab_ref_type'{
    spare:  reg_wdata[`TAB_RC_SPARE],
    source: reg_wdata[`TAB_RC_SOURCE],
    delay:  reg_wdata[`TAB_RC_DELAY_HI:`TAB_RC_DELAY_LO],
    sleep:  reg_wdata[`TAB_RC_SLEEP],
    level:  reg_wdata[`TAB_RC_LEVEL]
  } : ref_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_r <= '0;
      ref_r <= '{spare: 1'b0, source: 1'b0, delay: 2'h0,
                 sleep: `TAB_RC_SLEEP_RST, level: 1'b0};
    end else begin
      buf_r <= buf_nxt;
      ref_r <= ref_nxt;
    end
  end

  // ************************************************************
  // Channel new data flags
  // ************************************************************
  logic [8:0] flag_r;
  wire logic [8:0] flag_nxt;
  // Results go to the buffer in buffer mode, flags stay idle
  wire logic [8:0] flag_set = result_stored & {9{~buf_r.enable}};

  genvar gi;
  generate
    for (gi = 0; gi < `TAB_CHANNELS; gi = gi + 1) begin : g_flag
      // Set wins so a result landing during readout is kept
      assign flag_nxt[gi] = flag_set[gi] |
        (flag_r[gi] & ~result_read_done[gi]);
    end
  endgenerate

  wire logic any_read   = |result_read_done;
  wire logic complete_nxt = set_done |
    (set_complete_flag_r & ~(any_read & ~(|flag_nxt)));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r              <= '0;
      set_complete_flag_r <= 1'b0;
    end else begin
      flag_r              <= flag_nxt;
      set_complete_flag_r <= complete_nxt;
    end
  end

  wire logic [15:0] status_word = {4'h0, set_complete_flag_r,
    flag_r[0], flag_r[1], flag_r[2], flag_r[3], flag_r[4], 1'b0,
    flag_r[5], flag_r[6], flag_r[7], flag_r[8], 1'b0};

  // ************************************************************
  // Result buffer pointers
  // ************************************************************
  logic [6:0] count_r;
  wire logic [6:0] trig_level = {1'b0, buf_r.level, 3'h0} +
    `TAB_LEVEL_STEP;
  wire logic push_ok = buf_r.enable & buf_push & ~buffer_full_flag_r;
  wire logic pop_ok  = buf_r.enable & buf_pop & ~buffer_empty_flag_r;
  wire logic [6:0] count_step = count_r + 7'h01;
  wire logic [6:0] count_back = count_r - 7'h01;
  wire logic [6:0] count_nxt = ~buf_r.enable ? 7'h00 :
    (push_ok & ~pop_ok) ? count_step :
    (pop_ok & ~push_ok) ? count_back : count_r;
  wire logic trig_hit = push_ok & ~pop_ok &
    (count_nxt == trig_level);
  wire logic [5:0] wr_ptr_inc = buffer_write_pointer_r + 6'h01;
  wire logic [5:0] rd_ptr_inc = buffer_read_pointer_r + 6'h01;
  // Single shot stops conversions once the trigger level is held
  wire logic hold_nxt = buf_r.enable & buf_r.oneshot &
    (count_nxt >= trig_level);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r                  <= 7'h00;
      buffer_write_pointer_r   <= 6'h00;
      buffer_read_pointer_r    <= 6'h00;
      buffer_trigger_pointer_r <= 6'h00;
      buffer_full_flag_r       <= 1'b0;
      buffer_empty_flag_r      <= 1'b1;
      buffer_trigger_r         <= 1'b0;
      conv_hold_r              <= 1'b0;
    end else begin
      count_r             <= count_nxt;
      buffer_full_flag_r  <= (count_nxt == `TAB_BUF_DEPTH);
      buffer_empty_flag_r <= (count_nxt == 7'h00);
      buffer_trigger_r    <= trig_hit;
      conv_hold_r         <= hold_nxt;
      if (!buf_r.enable) begin
        buffer_write_pointer_r   <= 6'h00;
        buffer_read_pointer_r    <= 6'h00;
        buffer_trigger_pointer_r <= 6'h00;
      end else begin
        if (push_ok) begin
          buffer_write_pointer_r <= wr_ptr_inc;
        end
        if (pop_ok) begin
          buffer_read_pointer_r <= rd_ptr_inc;
        end
        if (trig_hit) begin
          buffer_trigger_pointer_r <= wr_ptr_inc;
        end
      end
    end
  end

  wire logic [15:0] bufctl_word = {buf_r.enable, buf_r.oneshot,
    buf_r.level, buffer_full_flag_r, buffer_empty_flag_r,
    9'h000};

  // ************************************************************
  // Reference sequencer
  // ************************************************************
  tab_pkg::tab_ref_state_type ref_state_r;
  tab_pkg::tab_ref_state_type ref_state_nxt;
  logic [15:0] wake_cnt_r;
  logic [15:0] wake_cnt_nxt;

  wire logic internal_ref = ref_r.source;
  // Wait applies only when the reference was actually off
  wire logic need_wait = internal_ref & ref_r.sleep &
    (ref_r.delay != 2'h0);
  wire logic [15:0] wake_load =
    (ref_r.delay == 2'h1) ? 16'(P_WAKE1_CYC) :
    (ref_r.delay == 2'h2) ? 16'(P_WAKE2_CYC) :
    16'(P_WAKE3_CYC);

  always_comb begin
    ref_state_nxt = ref_state_r;
    wake_cnt_nxt  = wake_cnt_r;
    case (ref_state_r)
      tab_pkg::TAB_REF_IDLE: begin
        if (conv_request) begin
          if (need_wait) begin
            wake_cnt_nxt  = wake_load;
            ref_state_nxt = tab_pkg::TAB_REF_WAKE;
          end else begin
            ref_state_nxt = tab_pkg::TAB_REF_READY;
          end
        end
      end
      tab_pkg::TAB_REF_WAKE: begin
        if (!conv_request) begin
          ref_state_nxt = tab_pkg::TAB_REF_IDLE;
        end else if (wake_cnt_r <= 16'h0001) begin
          ref_state_nxt = tab_pkg::TAB_REF_READY;
        end else begin
          wake_cnt_nxt = wake_cnt_r - 16'h0001;
        end
      end
      tab_pkg::TAB_REF_READY: begin
        if (!conv_request) begin
          ref_state_nxt = tab_pkg::TAB_REF_IDLE;
        end
      end
      default: begin
        ref_state_nxt = tab_pkg::TAB_REF_IDLE;
      end
    endcase
  end

  // External mode never powers the internal reference
  wire logic power_nxt = internal_ref & (~ref_r.sleep |
    (ref_state_nxt != tab_pkg::TAB_REF_IDLE));
  wire logic ready_nxt = (ref_state_nxt == tab_pkg::TAB_REF_READY);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_state_r               <= tab_pkg::TAB_REF_IDLE;
      wake_cnt_r                <= 16'h0000;
      ref_power_on_r            <= 1'b0;
      meas_ready_r              <= 1'b0;
      reference_source_select_r <= 1'b0;
      internal_level_select_r   <= 1'b0;
    end else begin
      ref_state_r               <= ref_state_nxt;
      wake_cnt_r                <= wake_cnt_nxt;
      ref_power_on_r            <= power_nxt;
      meas_ready_r              <= ready_nxt;
      reference_source_select_r <= ref_nxt.source;
      internal_level_select_r   <= ref_nxt.level;
    end
  end

  wire logic [15:0] refctl_word = {10'h000, ref_r.spare, ref_r.source,
    ref_r.delay, ref_r.sleep, ref_r.level};

  // ************************************************************
  // Read data
  // ************************************************************
  // Unmapped addresses answer zero rather than stale data
  wire logic [15:0] rd_sel = hit_status ? status_word :
    hit_bufctl ? bufctl_word :
    hit_refctl ? refctl_word : 16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r  <= 16'h0000;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rd_sel;
      end
    end
  end

endmodule

// >>> tb/tab_top_asserts.sv
// Port-level assertions for the status and reference block
module tab_top_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [5:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_rvalid_r,
  input wire logic        set_done,
  input wire logic        buf_push,
  input wire logic        buf_pop,
  input wire logic        conv_request,
  input wire logic        set_complete_flag_r,
  input wire logic        buffer_full_flag_r,
  input wire logic        buffer_empty_flag_r,
  input wire logic        buffer_trigger_r,
  input wire logic        meas_ready_r,
  input wire logic        ref_power_on_r,
  input wire logic        reference_source_select_r,
  input wire logic        internal_level_select_r,
  input wire logic [5:0]  buffer_read_pointer_r,
  input wire logic [5:0]  buffer_write_pointer_r,
  input wire logic [5:0]  buffer_trigger_pointer_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_full_empty_excl: assert property (
    !(buffer_full_flag_r && buffer_empty_flag_r))
    else $error("full and empty high together");
  a_read_answer: assert property (reg_rd |=> reg_rvalid_r)
    else $error("read not answered");
  a_no_stray_valid: assert property (!reg_rd |=> !reg_rvalid_r)
    else $error("answer without read");
  a_ext_ref_off: assert property (
    !reference_source_select_r && !$past(reference_source_select_r)
    |-> !ref_power_on_r) else $error("reference on in external mode");
  a_disable_clears: assert property (
    reg_wr && reg_addr == 6'h02 && !reg_wdata[15] |=> ##1
    ((buffer_read_pointer_r | buffer_write_pointer_r |
      buffer_trigger_pointer_r) == 6'h00 && buffer_empty_flag_r))
    else $error("disable left pointers");
  a_ref_fields: assert property (
    reg_wr && reg_addr == 6'h03 |=>
    internal_level_select_r == $past(reg_wdata[0]) &&
    reference_source_select_r == $past(reg_wdata[4]))
    else $error("reference fields not taken");
  a_trigger_cause: assert property (
    buffer_trigger_r |-> $past(buf_push) && !$past(buf_pop))
    else $error("trigger without push");
  a_ready_drop: assert property (
    !conv_request ##1 !conv_request |-> ##1 !meas_ready_r)
    else $error("ready without request");
  a_ready_direct: assert property (
    $rose(conv_request) && !reference_source_select_r |-> ##[1:2]
    meas_ready_r) else $error("external reference waited");
  a_set_flag: assert property (set_done |=> set_complete_flag_r)
    else $error("set complete flag not raised");
endmodule

bind tab_top tab_top_asserts u_chk (
  .clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rvalid_r,
  .set_done, .buf_push, .buf_pop, .conv_request, .set_complete_flag_r,
  .buffer_full_flag_r, .buffer_empty_flag_r, .buffer_trigger_r,
  .meas_ready_r, .ref_power_on_r, .reference_source_select_r,
  .internal_level_select_r, .buffer_read_pointer_r,
  .buffer_write_pointer_r, .buffer_trigger_pointer_r
);

// >>> tb/tab_host_model.sv
// Host processor model on the word-level register port
module tab_host_model (
  input  wire logic        clk,
  output logic      [5:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata_r,
  input  wire logic        reg_rvalid_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bus cycles
  // ****
  initial begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = (a == 6'h03) ? (d & 16'hFFDF) : d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid_r === 1'b1) ? reg_rdata_r : 16'hXXXX;
  endtask
endmodule

// >>> tb/touch_adc_status_buffer_ref_ctrl_test.sv
// Self-checking bench for the status and reference block
module touch_adc_status_buffer_ref_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, set_done, buf_push, buf_pop, conv_request;
  logic [8:0]  result_stored, result_read_done;
  logic [5:0]  reg_addr;
  logic        reg_wr, reg_rd, reg_rvalid_r;
  logic [15:0] reg_wdata, reg_rdata_r, v;
  logic        set_complete_flag_r, buffer_full_flag_r, buffer_empty_flag_r;
  logic        buffer_trigger_r, conv_hold_r, ref_power_on_r, meas_ready_r;
  logic        reference_source_select_r, internal_level_select_r;
  logic [5:0]  buffer_read_pointer_r, buffer_write_pointer_r;
  logic [5:0]  buffer_trigger_pointer_r;
  logic [2:0]  c;
  int          failures, check_count, cycles, trig_seen, k, seed;
  logic [15:0] rv [6] = '{16'h0012, 16'h0016, 16'h001A, 16'h001E,
                          16'h000E, 16'h001C};
  int          rn [6] = '{0, 5, 10, 20, 0, 0};
  // ****
  // Design and host
  // ****
  tab_top #(.P_WAKE1_CYC(5), .P_WAKE2_CYC(10), .P_WAKE3_CYC(20)) dut (
    .clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r,
    .reg_rvalid_r, .result_stored, .result_read_done, .set_done, .buf_push,
    .buf_pop, .conv_request, .set_complete_flag_r, .buffer_full_flag_r,
    .buffer_empty_flag_r, .buffer_trigger_r, .conv_hold_r, .ref_power_on_r,
    .meas_ready_r, .reference_source_select_r, .internal_level_select_r,
    .buffer_read_pointer_r, .buffer_write_pointer_r,
    .buffer_trigger_pointer_r);
  tab_host_model host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_r, .reg_rvalid_r);
  // ****
  // Helpers
  // ****
  function automatic logic [15:0] st_bit(input int i);
    int pos [9] = '{10, 9, 8, 7, 6, 4, 3, 2, 1};
    return 16'h0001 << pos[i];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic ev(input logic [8:0] st, rdn, input logic sd, p, q);
    @(negedge clk);
    result_stored = st;
    result_read_done = rdn;
    set_done = sd;
    buf_push = p;
    buf_pop = q;
    @(negedge clk);
    {result_stored, result_read_done, set_done, buf_push, buf_pop} = '0;
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Ceiling well above the expected run of about seven hundred fifty cycles
  always @(posedge clk) begin
    cycles++;
    if (buffer_trigger_r === 1'b1)
      trig_seen++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    rst = 1'b1;
    {result_stored, result_read_done, set_done, buf_push, buf_pop} = '0;
    conv_request = 1'b0;
    seed = $urandom(32'h646FC464);
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    rdchk(6'h01, 16'h0000);
    rdchk(6'h02, 16'h0200);
    rdchk(6'h03, 16'h0002);
    rdchk(6'h3F, 16'h0000);
    repeat (4) begin
      v = 16'($urandom) & 16'h001F;
      host.wr(6'h03, v | 16'hFFC0);
      rdchk(6'h03, v);
      chk(16'({reference_source_select_r, internal_level_select_r}),
          16'({v[4], v[0]}));
    end
    for (int i = 0; i < 9; i++) begin
      ev(9'h001 << i, 9'h000, 1'b1, 1'b0, 1'b0);
      rdchk(6'h01, st_bit(i) | 16'h0800);
      rdchk(6'h01, st_bit(i) | 16'h0800);
      ev(9'h000, 9'h001 << i, 1'b0, 1'b0, 1'b0);
      rdchk(6'h01, 16'h0000);
    end
    // Two flags pending; Y set and cleared in one cycle keeps Y
    ev(9'h003, 9'h000, 1'b1, 1'b0, 1'b0);
    ev(9'h002, 9'h003, 1'b0, 1'b0, 1'b0);
    rdchk(6'h01, st_bit(1) | 16'h0800);
    ev(9'h000, 9'h002, 1'b0, 1'b0, 1'b0);
    rdchk(6'h01, 16'h0000);
    for (int m = 0; m < 2; m++) begin
      c = (m == 1) ? 3'h7 : 3'($urandom);
      host.wr(6'h02, {1'b1, m[0], c, 11'h000});
      trig_seen = 0;
      repeat (8 * (c + 1)) ev(9'h000, 9'h000, 1'b0, 1'b1, 1'b0);
      repeat (2) @(negedge clk);
      chk(16'(trig_seen), 16'h0001);
      chk(16'(conv_hold_r), 16'(m));
      ev(9'h001, 9'h000, 1'b0, 1'b0, 1'b0);
      rdchk(6'h01, 16'h0000);
      repeat (56 - 8 * c) ev(9'h000, 9'h000, 1'b0, 1'b1, 1'b0);
      rdchk(6'h02, {1'b1, m[0], c, 11'h400});
      chk(16'({buffer_full_flag_r, buffer_trigger_pointer_r}),
          16'({1'b1, 6'(8 * (c + 1))}));
      repeat (64) ev(9'h000, 9'h000, 1'b0, 1'b0, 1'b1);
      rdchk(6'h02, {1'b1, m[0], c, 11'h200});
      ev(9'h000, 9'h000, 1'b0, 1'b1, 1'b0);
      host.wr(6'h02, 16'h0000);
      // Pointers clear one edge after the enable bit falls
      @(negedge clk);
      chk(16'(buffer_read_pointer_r | buffer_write_pointer_r |
          buffer_trigger_pointer_r), 16'h0000);
    end
    for (int i = 0; i < 6; i++) begin
      host.wr(6'h03, rv[i]);
      @(negedge clk) conv_request = 1'b1;
      k = 0;
      while (meas_ready_r !== 1'b1 && k < 100) begin
        @(negedge clk);
        k++;
      end
      chk(16'(k >= rn[i] && k <= rn[i] + 3), 16'h0001);
      chk(16'(ref_power_on_r), 16'(rv[i][4]));
      @(negedge clk) conv_request = 1'b0;
      repeat (2) @(negedge clk);
      chk(16'(ref_power_on_r), 16'(rv[i][4] & ~rv[i][1]));
    end
    end_sim();
  end
endmodule
